// File: dcg_pkg.sv
// ---------------------------------------------------------------
// register map and field layout
// ---------------------------------------------------------------
package dcg_pkg;

   // word-aligned byte offsets on the register port
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_SEED    = 8'h04;
   localparam logic [7:0] ADDR_TAPS    = 8'h08;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CHAN_W = 3;
   localparam int POLY_LENGTH_M1_W = 5;
   localparam int HALF_W = 16;

   // crc_control field positions
   localparam int POS_BYTE_ORDER_LO = 28;
   localparam int POS_BYTE_ORDER_HI = 29;
   localparam int POS_WRITE_REORDER = 27;
   localparam int POS_BIT_REFLECT   = 24;
   localparam int POS_POLY_LENGTH_M1_LO       = 8;
   localparam int POS_POLY_LENGTH_M1_HI       = 12;
   localparam int POS_ENABLE        = 7;
   localparam int POS_APPEND        = 6;
   localparam int POS_CALC_TYPE     = 5;
   localparam int POS_CHAN_LO       = 0;
   localparam int POS_CHAN_HI       = 2;

   // byte order encodings
   localparam logic [1:0] BYTE_ORDER_NONE  = 2'h0;
   localparam logic [1:0] BYTE_ORDER_WORD  = 2'h1;
   localparam logic [1:0] BYTE_ORDER_HALF  = 2'h2;
   localparam logic [1:0] BYTE_ORDER_INHW  = 2'h3;

   // reset values
   localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
   localparam logic [4:0]  RESET_POLY_LENGTH_M1  = 5'h00;
   localparam logic [2:0]  RESET_CHAN  = 3'h0;
   localparam logic [1:0]  RESET_ORDER = 2'h0;
   localparam logic [15:0] RESET_HALF  = 16'h0000;

endpackage : dcg_pkg

// File: dcg_byte_reorder.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// byte reordering of one source word
// ---------------------------------------------------------------
module dcg_byte_reorder (
   input  wire logic [1:0]  order_sel,
   input  wire logic [31:0] data_in,
   output logic      [31:0] data_out
);

   // pure wiring, so it costs no cycle in the data path
   always_comb begin
      case (order_sel)
         dcg_pkg::BYTE_ORDER_NONE: data_out = data_in;
         dcg_pkg::BYTE_ORDER_WORD: data_out = {data_in[7:0], data_in[15:8],
                                               data_in[23:16], data_in[31:24]};
         dcg_pkg::BYTE_ORDER_HALF: data_out = {data_in[15:0], data_in[31:16]};
         dcg_pkg::BYTE_ORDER_INHW: data_out = {data_in[23:16], data_in[31:24],
                                               data_in[7:0], data_in[15:8]};
         default:                  data_out = data_in;
      endcase
   end

endmodule : dcg_byte_reorder

// File: dcg_crc_step.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// one data word through the lfsr or the checksum adder
// ---------------------------------------------------------------
module dcg_crc_step (
   input  wire logic [31:0] state_in,
   input  wire logic [31:0] data_in,
   input  wire logic [31:0] taps,
   input  wire logic [4:0]  poly_length_m1_m1,
   input  wire logic [31:0] len_mask,
   input  wire logic        reflect,
   input  wire logic        ip_mode,
   output logic      [31:0] state_out
);

   // 32 serial lfsr steps unrolled into one cycle; long path, but one word per clock
   always_comb begin
      logic [31:0] s;
      logic [31:0] n;
      logic [15:0] hi;
      logic [15:0] lo;
      logic [16:0] acc;
      logic        fb;
      logic        d;
      s   = state_in;
      n   = '0;
      hi  = data_in[31:16];
      lo  = data_in[15:0];
      acc = '0;
      fb  = 1'b0;
      d   = 1'b0;
      if (ip_mode) begin
         if (reflect) begin
            for (int i = 0; i < 16; i++) begin
               hi[i] = data_in[31 - i];
               lo[i] = data_in[15 - i];
            end
         end
         // end-around carry keeps the one's complement sum
         acc = {1'b0, s[15:0]} + {1'b0, hi};
         acc = {1'b0, acc[15:0]} + {16'h0000, acc[16]};
         acc = {1'b0, acc[15:0]} + {1'b0, lo};
         acc = {1'b0, acc[15:0]} + {16'h0000, acc[16]};
         state_out = {16'h0000, acc[15:0]};
      end else begin
         for (int k = 0; k < 32; k++) begin
            d  = reflect ? data_in[k] : data_in[31 - k];
            fb = d ^ s[poly_length_m1_m1];
            n[0] = taps[0] & fb;
            for (int i = 1; i < 32; i++) begin
               n[i] = s[i - 1] ^ (taps[i] & fb);
            end
            s = n & len_mask;
         end
         state_out = s;
      end
   end

endmodule : dcg_crc_step

// File: dcg_top.sv
`timescale 1ns/1ps
module dcg_top (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_we,
   input  wire logic        reg_re,
   output logic      [31:0] reg_rdata,
   input  wire logic        xfer_valid,
   input  wire logic [2:0]  xfer_channel,
   input  wire logic [31:0] xfer_data,
   input  wire logic        xfer_unaligned,
   input  wire logic        block_done,
   input  wire logic [2:0]  block_channel,
   input  wire logic [31:0] channel_dest_start_addr,
   output logic             crc_route,
   output logic             unaligned_reject,
   output logic             dest_valid,
   output logic      [31:0] dest_data,
   output logic             append_valid,
   output logic      [31:0] append_addr,
   output logic      [31:0] append_data
);

   // ---------------------------------------------------------------
   // control register state
   // ---------------------------------------------------------------
   logic [1:0]  byte_order_sel;
   logic        write_reorder_en;
   logic        bit_reflect_sel;
   logic [4:0]  poly_length_m1;
   logic        checksum_enable;
   logic        append_result_mode;
   logic        calc_type_sel;
   logic [2:0]  channel_assign_sel;
   logic [31:0] crc_feedback_taps;
   logic [31:0] crc_state;

   logic [1:0]  next_byte_order_sel;
   logic        next_write_reorder_en;
   logic        next_bit_reflect_sel;
   logic [4:0]  next_poly_length_m1;
   logic        next_checksum_enable;
   logic        next_append_result_mode;
   logic        next_calc_type_sel;
   logic [2:0]  next_channel_assign_sel;
   logic [31:0] next_crc_feedback_taps;
   logic [31:0] next_crc_state;

   logic        wr_control;
   logic        wr_seed;
   logic        wr_taps;
   logic        unit_take;
   logic [31:0] len_mask;
   logic [31:0] reordered;
   logic [31:0] stepped;
   logic [31:0] readback_now;
   logic [31:0] readback_next;

   assign wr_control = reg_we && (reg_addr == dcg_pkg::ADDR_CONTROL);
   assign wr_seed    = reg_we && (reg_addr == dcg_pkg::ADDR_SEED);
   assign wr_taps    = reg_we && (reg_addr == dcg_pkg::ADDR_TAPS);

   // ---------------------------------------------------------------
   // length mask, one bit per stage
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_mask
         assign len_mask[g] = (5'(g) <= poly_length_m1);
      end
   endgenerate

   // ---------------------------------------------------------------
   // channel routing and unit acceptance
   // ---------------------------------------------------------------
   // routing is combinational so the dma sees it in the same cycle
   assign crc_route        = checksum_enable && (xfer_channel == channel_assign_sel);
   assign unaligned_reject = crc_route && xfer_valid && write_reorder_en
                             && xfer_unaligned;
   assign unit_take        = crc_route && xfer_valid && !unaligned_reject;

   dcg_byte_reorder u_reorder (
      .order_sel (byte_order_sel),
      .data_in   (xfer_data),
      .data_out  (reordered)
   );

   dcg_crc_step u_step (
      .state_in  (crc_state),
      .data_in   (reordered),
      .taps      (crc_feedback_taps),
      .poly_length_m1_m1   (poly_length_m1),
      .len_mask  (len_mask),
      .reflect   (bit_reflect_sel),
      .ip_mode   (calc_type_sel),
      .state_out (stepped)
   );

   // ---------------------------------------------------------------
   // control and taps registers
   // ---------------------------------------------------------------
   // append is forced clear whenever the same write asks for write reorder
   always_comb begin
      next_byte_order_sel     = byte_order_sel;
      next_write_reorder_en   = write_reorder_en;
      next_bit_reflect_sel    = bit_reflect_sel;
      next_poly_length_m1     = poly_length_m1;
      next_checksum_enable    = checksum_enable;
      next_append_result_mode = append_result_mode;
      next_calc_type_sel      = calc_type_sel;
      next_channel_assign_sel = channel_assign_sel;
      next_crc_feedback_taps  = crc_feedback_taps;
      if (wr_control) begin
         next_byte_order_sel     = reg_wdata[dcg_pkg::POS_BYTE_ORDER_HI:dcg_pkg::POS_BYTE_ORDER_LO];
         next_write_reorder_en   = reg_wdata[dcg_pkg::POS_WRITE_REORDER];
         next_bit_reflect_sel    = reg_wdata[dcg_pkg::POS_BIT_REFLECT];
         next_poly_length_m1     = reg_wdata[dcg_pkg::POS_POLY_LENGTH_M1_HI:dcg_pkg::POS_POLY_LENGTH_M1_LO];
         next_checksum_enable    = reg_wdata[dcg_pkg::POS_ENABLE];
         next_append_result_mode = reg_wdata[dcg_pkg::POS_APPEND]
                                   && !reg_wdata[dcg_pkg::POS_WRITE_REORDER];
         next_calc_type_sel      = reg_wdata[dcg_pkg::POS_CALC_TYPE];
         next_channel_assign_sel = reg_wdata[dcg_pkg::POS_CHAN_HI:dcg_pkg::POS_CHAN_LO];
      end
      if (wr_taps) begin
         next_crc_feedback_taps = reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         byte_order_sel     <= dcg_pkg::RESET_ORDER;
         write_reorder_en   <= 1'b0;
         bit_reflect_sel    <= 1'b0;
         poly_length_m1     <= dcg_pkg::RESET_POLY_LENGTH_M1;
         checksum_enable    <= 1'b0;
         append_result_mode <= 1'b0;
         calc_type_sel      <= 1'b0;
         channel_assign_sel <= dcg_pkg::RESET_CHAN;
         crc_feedback_taps  <= dcg_pkg::RESET_WORD;
      end else begin
         byte_order_sel     <= next_byte_order_sel;
         write_reorder_en   <= next_write_reorder_en;
         bit_reflect_sel    <= next_bit_reflect_sel;
         poly_length_m1     <= next_poly_length_m1;
         checksum_enable    <= next_checksum_enable;
         append_result_mode <= next_append_result_mode;
         calc_type_sel      <= next_calc_type_sel;
         channel_assign_sel <= next_channel_assign_sel;
         crc_feedback_taps  <= next_crc_feedback_taps;
      end
   end

   // ---------------------------------------------------------------
   // generator state
   // ---------------------------------------------------------------
   // a seed write in the same cycle as a unit wins; software owns the restart
   always_comb begin
      next_crc_state = crc_state;
      if (unit_take) begin
         next_crc_state = stepped;
      end
      if (wr_seed) begin
         if (calc_type_sel) begin
            next_crc_state = {dcg_pkg::RESET_HALF, ~reg_wdata[15:0]};
         end else begin
            next_crc_state = reg_wdata & len_mask;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         crc_state <= dcg_pkg::RESET_WORD;
      end else begin
         crc_state <= next_crc_state;
      end
   end

   // checksum reads show the complement, lfsr reads are masked to length
   function automatic logic [31:0] shown(input logic [31:0] st, input logic ip, input logic [31:0] msk);
      logic [31:0] v;
      v = ip ? {dcg_pkg::RESET_HALF, ~st[15:0]} : (st & msk);
      return v;
   endfunction : shown

   assign readback_now  = shown(crc_state, calc_type_sel, len_mask);
   assign readback_next = shown(next_crc_state, calc_type_sel, len_mask);

   // ---------------------------------------------------------------
   // destination and append outputs
   // ---------------------------------------------------------------
   logic        next_dest_valid;
   logic [31:0] next_dest_data;
   logic        next_append_valid;
   logic [31:0] next_append_addr;
   logic [31:0] next_append_data;

   // append result is taken from the next state so a last unit in the done cycle counts
   always_comb begin
      next_dest_valid   = 1'b0;
      next_dest_data    = dest_data;
      next_append_valid = 1'b0;
      next_append_addr  = append_addr;
      next_append_data  = append_data;
      if (unit_take && !append_result_mode) begin
         next_dest_valid = 1'b1;
         next_dest_data  = write_reorder_en ? reordered : xfer_data;
      end
      if (block_done && checksum_enable && append_result_mode
          && (block_channel == channel_assign_sel)) begin
         next_append_valid = 1'b1;
         next_append_addr  = channel_dest_start_addr;
         next_append_data  = readback_next;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dest_valid   <= 1'b0;
         dest_data    <= dcg_pkg::RESET_WORD;
         append_valid <= 1'b0;
         append_addr  <= dcg_pkg::RESET_WORD;
         append_data  <= dcg_pkg::RESET_WORD;
      end else begin
         dest_valid   <= next_dest_valid;
         dest_data    <= next_dest_data;
         append_valid <= next_append_valid;
         append_addr  <= next_append_addr;
         append_data  <= next_append_data;
      end
   end

   // ---------------------------------------------------------------
   // register read port
   // ---------------------------------------------------------------
   logic [31:0] next_reg_rdata;
   logic [31:0] control_word;

   // unimplemented bits and unmapped offsets read as zero
   always_comb begin
      control_word = '0;
      control_word[dcg_pkg::POS_BYTE_ORDER_HI:dcg_pkg::POS_BYTE_ORDER_LO] = byte_order_sel;
      control_word[dcg_pkg::POS_WRITE_REORDER] = write_reorder_en;
      control_word[dcg_pkg::POS_BIT_REFLECT]   = bit_reflect_sel;
      control_word[dcg_pkg::POS_POLY_LENGTH_M1_HI:dcg_pkg::POS_POLY_LENGTH_M1_LO] = poly_length_m1;
      control_word[dcg_pkg::POS_ENABLE]        = checksum_enable;
      control_word[dcg_pkg::POS_APPEND]        = append_result_mode;
      control_word[dcg_pkg::POS_CALC_TYPE]     = calc_type_sel;
      control_word[dcg_pkg::POS_CHAN_HI:dcg_pkg::POS_CHAN_LO] = channel_assign_sel;
      next_reg_rdata = '0;
      if (reg_re) begin
         case (reg_addr)
            dcg_pkg::ADDR_CONTROL: next_reg_rdata = control_word;
            dcg_pkg::ADDR_SEED:    next_reg_rdata = readback_now;
            dcg_pkg::ADDR_TAPS:    next_reg_rdata = crc_feedback_taps;
            default:               next_reg_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= dcg_pkg::RESET_WORD;
      end else begin
         reg_rdata <= next_reg_rdata;
      end
   end

endmodule : dcg_top

// File: dcg_checker.sv
`timescale 1ns/1ps
// ------------------------------------------
// port checker for the crc generator
// ------------------------------------------
module dcg_checker (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_we,
   input wire logic        reg_re,
   input wire logic [31:0] reg_rdata,
   input wire logic        xfer_valid,
   input wire logic [2:0]  xfer_channel,
   input wire logic [31:0] xfer_data,
   input wire logic        xfer_unaligned,
   input wire logic        block_done,
   input wire logic [2:0]  block_channel,
   input wire logic [31:0] channel_dest_start_addr,
   input wire logic        crc_route,
   input wire logic        unaligned_reject,
   input wire logic        dest_valid,
   input wire logic [31:0] dest_data,
   input wire logic        append_valid,
   input wire logic [31:0] append_addr,
   input wire logic [31:0] append_data
);
   logic [31:0] ctl, next_ctl, exp_dest, next_exp_dest, len_mask;
   logic        acc, pass;

   function automatic logic [31:0] ro(logic [1:0] s, logic [31:0] d);
      case (s)
         2'h1:    return {d[7:0], d[15:8], d[23:16], d[31:24]};
         2'h2:    return {d[15:0], d[31:16]};
         2'h3:    return {d[23:16], d[31:24], d[7:0], d[15:8]};
         default: return d;
      endcase
   endfunction : ro

   // shadow of control; append is dropped when write reorder comes with it
   always_comb begin
      next_ctl = ctl;
      next_exp_dest = exp_dest;
      if (reg_we && reg_addr == dcg_pkg::ADDR_CONTROL) begin
         next_ctl = reg_wdata & 32'h3900_1FE7;
         if (reg_wdata[27]) next_ctl[6] = 1'b0;
      end
      if (acc) next_exp_dest = ctl[27] ? ro(ctl[29:28], xfer_data) : xfer_data;
   end
   always_ff @(posedge clk) begin
      ctl      <= rst ? 32'h0000_0000 : next_ctl;
      exp_dest <= next_exp_dest;
   end
   // accepted unit, and the mask of a programmed length
   assign acc = xfer_valid && crc_route && !unaligned_reject;
   assign pass = acc && !ctl[6];
   assign len_mask = ~(32'hFFFF_FFFE << ctl[12:8]);

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_route_match: assert property (crc_route == (ctl[7] && xfer_channel == ctl[2:0]))
      else $error("crc_route wrong");
   a_unal_reject: assert property (unaligned_reject == (xfer_valid && crc_route && xfer_unaligned && ctl[27]))
      else $error("unaligned_reject wrong");
   a_ctrl_read: assert property (reg_re && reg_addr == dcg_pkg::ADDR_CONTROL |=> reg_rdata == ctl)
      else $error("control readback wrong");
   a_dest_pass: assert property (pass |=> dest_valid)
      else $error("dest_valid missing");
   a_dest_cause: assert property (dest_valid |-> $past(pass))
      else $error("dest_valid without unit");
   a_dest_order: assert property (dest_valid |-> dest_data == exp_dest)
      else $error("dest_data order wrong");
   a_append_quiet: assert property (acc && ctl[6] |=> !dest_valid)
      else $error("dest write in append mode");
   a_append_done: assert property (block_done && ctl[7] && ctl[6] && block_channel == ctl[2:0]
      |=> append_valid && append_addr == $past(channel_dest_start_addr))
      else $error("append write wrong");
   a_lfsr_upper: assert property (reg_re && reg_addr == dcg_pkg::ADDR_SEED && !ctl[5]
      |=> (reg_rdata & ~len_mask) == '0)
      else $error("bits above length not zero");
   a_ip_upper: assert property (reg_re && reg_addr == dcg_pkg::ADDR_SEED && ctl[5]
      |=> reg_rdata[31:16] == 16'h0000)
      else $error("checksum upper half not zero");
   a_seed_echo: assert property (reg_we && reg_addr == dcg_pkg::ADDR_SEED && ctl[5] ##1 !xfer_valid
      ##1 reg_re && reg_addr == dcg_pkg::ADDR_SEED |=> reg_rdata == ($past(reg_wdata, 3) & 32'h0000_FFFF))
      else $error("checksum seed echo wrong");

   // main scenarios reached
   c_append: cover property (append_valid);
   c_reject: cover property (unaligned_reject);
   c_reorder: cover property (dest_valid && ctl[27]);
endmodule : dcg_checker

bind dcg_top dcg_checker i_chk (.*);

// File: dcg_dma_model.sv
`timescale 1ns/1ps
// ------------------------------------------
// dma channel source feeding the generator
// ------------------------------------------
module dcg_dma_model #(
   parameter logic [31:0] DEST_ADDR = 32'h0000_0100
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic [2:0]  chan,
   input  wire logic [7:0]  count,
   input  wire logic [31:0] first,
   input  wire logic        slow,
   input  wire logic        unal,
   output logic             busy,
   output logic             xfer_valid,
   output logic      [2:0]  xfer_channel,
   output logic      [31:0] xfer_data,
   output logic             xfer_unaligned,
   output logic             block_done,
   output logic      [2:0]  block_channel,
   output logic      [31:0] channel_dest_start_addr
);
   logic [7:0]  left = 8'h00;
   logic [31:0] word = 32'h0000_0000;

   assign busy = left != 8'h00;
   assign channel_dest_start_addr = DEST_ADDR;

   // known levels before the first edge
   initial begin
      xfer_valid = 1'b0;
      xfer_channel = 3'h0;
      xfer_data = 32'h0000_0000;
      xfer_unaligned = 1'b0;
      block_done = 1'b0;
      block_channel = 3'h0;
   end
   // data lines toggle outside units so a stale word is never mistaken for a live one
   always @(posedge clk) begin
      xfer_valid <= 1'b0;
      block_done <= 1'b0;
      xfer_data  <= ~xfer_data;
      if (rst) begin
         left <= 8'h00;
      end else if (start) begin
         left           <= count;
         word           <= first;
         xfer_channel   <= chan;
         block_channel  <= chan;
         xfer_unaligned <= unal;
      end else if (busy && !(slow && xfer_valid)) begin
         xfer_valid <= 1'b1;
         xfer_data  <= word;
         word       <= word + 32'h0101_0101;
         left       <= left - 8'h01;
         block_done <= left == 8'h01;
      end
   end
endmodule : dcg_dma_model

// File: dcg_top_tb.sv
`timescale 1ns/1ps
// ------------------------------------------
// self-checking bench for the crc generator
// ------------------------------------------
module dcg_top_tb;
   localparam logic [31:0] DEST = 32'h2000_0100;
   localparam logic [7:0] CTL = dcg_pkg::ADDR_CONTROL, SEED = dcg_pkg::ADDR_SEED, TAP = dcg_pkg::ADDR_TAPS;
   typedef struct {logic [31:0] ctl, tap, seed, data, dest;} dcg_row_s;
   logic        clk = 0, rst = 1, reg_we = 0, reg_re = 0, start = 0, slow = 0, unal = 0;
   logic [7:0]  reg_addr = 8'h00, count = 8'h00;
   logic [31:0] reg_wdata = '0, first = '0;
   logic [2:0]  chan = 3'h0, xfer_channel, block_channel;
   logic [31:0] reg_rdata, xfer_data, channel_dest_start_addr, dest_data, append_addr, append_data;
   logic        busy, xfer_valid, xfer_unaligned, block_done, crc_route, unaligned_reject, dest_valid, append_valid;
   logic [31:0] cfg = 0, tps = 0, es = 0, last_dest;
   int          n_errors = 0, compares = 0, n_dest = 0, n_app = 0, d0, a0;
   dcg_row_s    rows [8] = '{
      '{32'h0000_1F80, 32'h04C1_1DB7, 32'hFFFF_FFFF, 32'h1234_5678, 32'h1234_5678},
      '{32'h1800_0F81, 32'h0000_1021, 32'h0000_FFFF, 32'h1234_5678, 32'h7856_3412},
      '{32'h2800_0782, 32'h0000_0007, 32'h0000_0000, 32'hA1B2_C3D4, 32'hC3D4_A1B2},
      '{32'h3800_0483, 32'h0000_0015, 32'h0000_001F, 32'hA1B2_C3D4, 32'hB2A1_D4C3},
      '{32'h3100_1F84, 32'hEDB8_8320, 32'hFFFF_FFFF, 32'h0102_0304, 32'h0102_0304},
      '{32'h0000_1FA5, 32'hFFFF_FFFF, 32'h0000_0000, 32'h4500_0073, 32'h4500_0073},
      '{32'h1900_0CA6, 32'h0000_0000, 32'h1234_ABCD, 32'h0000_C0A8, 32'hA8C0_0000},
      '{32'h0000_0087, 32'h0000_0001, 32'hFFFF_FFFF, 32'hDEAD_BEEF, 32'hDEAD_BEEF}};

   dcg_top i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .xfer_valid, .xfer_channel,
      .xfer_data, .xfer_unaligned, .block_done, .block_channel, .channel_dest_start_addr, .crc_route,
      .unaligned_reject, .dest_valid, .dest_data, .append_valid, .append_addr, .append_data);
   dcg_dma_model #(.DEST_ADDR(DEST)) i_dma (.clk, .rst, .start, .chan, .count, .first, .slow, .unal, .busy,
      .xfer_valid, .xfer_channel, .xfer_data, .xfer_unaligned, .block_done, .block_channel, .channel_dest_start_addr);

   // clock, and counters of destination and append writes
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (dest_valid === 1'b1) begin
         n_dest++;
         last_dest = dest_data;
      end
      if (append_valid === 1'b1) n_app++;
   end

   function automatic logic [31:0] msk(logic [4:0] p);
      return ~(32'hFFFF_FFFE << p);
   endfunction : msk
   function automatic logic [31:0] ro(logic [1:0] s, logic [31:0] d);
      case (s)
         2'h1:    return {d[7:0], d[15:8], d[23:16], d[31:24]};
         2'h2:    return {d[15:0], d[31:16]};
         2'h3:    return {d[23:16], d[31:24], d[7:0], d[15:8]};
         default: return d;
      endcase
   endfunction : ro
   // bit-serial reference; the sum keeps its end-around carry
   function automatic logic [31:0] step(logic [31:0] s, logic [31:0] d);
      logic [16:0] a;
      logic [15:0] h;
      logic        fb;
      for (int k = 0; k < 32; k++) begin
         if (cfg[5] && k < 2) begin
            h = (k == 0) ? d[31:16] : d[15:0];
            if (cfg[24]) h = {<<{h}};
            a = {1'b0, s[15:0]} + {1'b0, h};
            s = {16'h0000, a[15:0] + {15'h0000, a[16]}};
         end else if (!cfg[5]) begin
            fb = (cfg[24] ? d[k] : d[31-k]) ^ s[cfg[12:8]];
            s = ((s << 1) ^ (tps & {32{fb}})) & msk(cfg[12:8]);
         end
      end
      return s;
   endfunction : step
   function automatic logic [31:0] rb();
      return cfg[5] ? {16'h0000, ~es[15:0]} : es & msk(cfg[12:8]);
   endfunction : rb

   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic summarize();
      $display("compares %0d, n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // register port write, mirrored into the reference state
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
      if (a == CTL) cfg = d & (d[27] ? 32'h3900_1FA7 : 32'h3900_1FE7);
      if (a == TAP) tps = d;
      if (a == SEED) es = cfg[5] ? {16'h0000, ~d[15:0]} : d & msk(cfg[12:8]);
   endtask : wr
   task automatic rd(logic [7:0] a, logic [31:0] exp);
      @(posedge clk);
      reg_re   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 chk("reg_rdata", reg_rdata, exp);
   endtask : rd
   // one block; take says whether the crc absorbs it
   task automatic run(logic [2:0] c, logic [7:0] n, logic [31:0] f, logic s, logic u, logic take);
      logic [31:0] w;
      w = f;
      @(posedge clk);
      start <= 1'b1;
      {chan, count, first, slow, unal} <= {c, n, f, s, u};
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 300 && busy; k++) @(posedge clk);
      chk("busy", busy, 32'h0);
      if (busy) summarize();
      repeat (2) @(posedge clk);
      for (int k = 0; k < n && take; k++) begin
         es = step(es, ro(cfg[29:28], w));
         w = w + 32'h0101_0101;
      end
   endtask : run

   // main sequence: reset readback first, then table rows, then the awkward cases
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(CTL, 32'h0);
      rd(SEED, 32'h0);
      wr(8'h0C, 32'hFFFF_FFFF);
      rd(8'h0C, 32'h0);
      rd(TAP, 32'h0);
      foreach (rows[i]) begin
         wr(CTL, rows[i].ctl);
         wr(TAP, rows[i].tap);
         wr(SEED, rows[i].seed);
         rd(SEED, rb());
         rd(CTL, cfg);
         rd(TAP, rows[i].tap);
         d0 = n_dest;
         run(rows[i].ctl[2:0], 8'h01, rows[i].data, 1'b0, 1'b0, 1'b1);
         chk("dest count", n_dest - d0, 1);
         chk("dest_data", last_dest, rows[i].dest);
         rd(SEED, rb());
      end
      wr(CTL, 32'h0000_1F82);
      wr(SEED, 32'h89AB_CDEF);
      d0 = n_dest;
      run(3'h5, 8'h02, 32'h1111_2222, 1'b0, 1'b0, 1'b0);
      wr(CTL, 32'h0000_1F02);
      run(3'h2, 8'h02, 32'h3333_4444, 1'b0, 1'b0, 1'b0);
      chk("dest count", n_dest - d0, 0);
      rd(SEED, rb());
      wr(CTL, 32'h1000_1F83);
      d0 = n_dest;
      run(3'h3, 8'h06, 32'h0102_0304, 1'b0, 1'b0, 1'b1);
      run(3'h3, 8'h05, 32'hF0E0_D0C0, 1'b1, 1'b0, 1'b1);
      chk("dest count", n_dest - d0, 11);
      rd(SEED, rb());
      wr(CTL, 32'h0000_1FC1);
      wr(SEED, 32'hFFFF_FFFF);
      {d0, a0} = {n_dest, n_app};
      run(3'h1, 8'h03, 32'h5566_7788, 1'b0, 1'b0, 1'b1);
      chk("dest count", n_dest - d0, 0);
      chk("append count", n_app - a0, 1);
      chk("append_addr", append_addr, DEST);
      chk("append_data", append_data, rb());
      wr(CTL, 32'h0800_10C1);
      wr(SEED, 32'h0000_ACE1);
      rd(CTL, 32'h0800_1081);
      d0 = n_dest;
      run(3'h1, 8'h02, 32'h0A0B_0C0D, 1'b0, 1'b1, 1'b0);
      chk("dest count", n_dest - d0, 0);
      rd(SEED, rb());
      wr(CTL, 32'h0000_1081);
      run(3'h1, 8'h01, 32'h0A0B_0C0D, 1'b0, 1'b1, 1'b1);
      chk("dest count", n_dest - d0, 1);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rd(CTL, 32'h0);
      summarize();
   end
endmodule : dcg_top_tb
